// ==== src/isr_pkg.sv ====
// Purpose: shared constants for the instrument status reporting block
// Assumes: one clock, commands arrive already decoded from the remote parser
// Notes: bit positions are those of the status, standard, operation and questionable sets
package isr_pkg;
	// status byte summary bit positions
	localparam int SB_EAV = 2;
	localparam int SB_QSB = 3;
	localparam int SB_MAV = 4;
	localparam int SB_ESB = 5;
	localparam int SB_MSS = 6;
	localparam int SB_OSB = 7;
	// standard event bit positions
	localparam int SE_OPC = 0;
	localparam int SE_QYE = 2;
	localparam int SE_DSE = 3;
	localparam int SE_EXE = 4;
	localparam int SE_CME = 5;
	localparam int SE_PON = 7;
	// operation bit positions
	localparam int OP_WAIT_EVENT_WAIT_FLAG = 5;
	localparam int OP_WAIT_ARM = 6;
	localparam int OP_IDLE = 10;
	localparam int OP_INTERLOCK = 12;
	// questionable bit positions
	localparam int QU_CURRENT_CAP = 0;
	localparam int QU_VOLT_COMPL = 1;
	localparam int QU_CAL_FAULT = 8;
	localparam int QU_LINK_LOST = 9;
	// reset values
	localparam logic [7:0] SE_RESET = 8'h80;
	localparam logic [7:0] MASK8_RESET = 8'h00;
	localparam logic [15:0] MASK16_RESET = 16'h0000;
	localparam logic [15:0] NO_ERROR = 16'h0000;
	// error code ranges, as signed 16-bit codes
	localparam logic signed [15:0] CME_HI = -16'sd100;
	localparam logic signed [15:0] CME_LO = -16'sd184;
	localparam logic signed [15:0] EXE_HI = -16'sd200;
	localparam logic signed [15:0] EXE_LO = -16'sd294;
	localparam logic signed [15:0] DSE_HI = -16'sd300;
	localparam logic signed [15:0] DSE_LO = -16'sd365;
	localparam logic signed [15:0] QYE_HI = -16'sd400;
	localparam logic signed [15:0] QYE_LO = -16'sd440;
	localparam int ERR_DEPTH = 16;
	// host commands, already decoded
	typedef enum logic [4:0] {
		CMD_READ_STATUS,
		CMD_WRITE_SRE,
		CMD_READ_SRE,
		CMD_READ_ESR,
		CMD_WRITE_ESE,
		CMD_READ_ESE,
		CMD_READ_OPER_EVENT,
		CMD_READ_OPER_COND,
		CMD_WRITE_OPER_ENABLE,
		CMD_READ_OPER_ENABLE,
		CMD_READ_QUES_EVENT,
		CMD_READ_QUES_COND,
		CMD_WRITE_QUES_ENABLE,
		CMD_READ_QUES_ENABLE,
		CMD_CLEAR_STATUS,
		CMD_OP_COMPLETE,
		CMD_ERR_NEXT,
		CMD_ERR_ALL,
		CMD_ERR_CLEAR,
		CMD_ERR_COUNT
	} isr_cmd_e;
	typedef enum logic [0:0] {
		ST_IDLE,
		ST_DRAIN
	} isr_state_e;
endpackage : isr_pkg

// ==== src/isr_status_core.sv ====
// Purpose: status byte, event register sets and error queue of a remote instrument
// Assumes: commands are decoded upstream; condition inputs are synchronous to ref_clk
// Notes: every output is registered, so the status byte trails its sources by one cycle
// Contract
// - status byte summary bits follow their sources; clearing an event drops its summary
// - bit 4 shows a reply is waiting; clears when all replies are read
// - error-available bit stands while the error queue holds entries
// - bit 7 is any enabled operation event
// - bit 6 is any summary bit enabled by the request mask
// - status byte read changes nothing; master clears only via source or mask
// - service request output follows the master summary bit
// - bit 5 is any enabled standard event
// - bit 3 is any enabled questionable event
// - request mask is written and read back unchanged
// - standard event read returns then clears; its mask is writable and readable
// - standard bits: power-up 7, cmd 5, exec 4, device 3, query 2, done 0
// - command error flag set for uninterpretable commands
// - execution error flag set for out-of-bounds requests
// - query error flag set when reply data is lost
// - after the done command, done flag sets when no operation is pending
// - operation bits: interlock 12, idle 10, trigger wait 5
// - operation bit 6 is reserved and never sets
// - operation event read clears, condition read is live, mask is read/write
// - questionable bits: link 9, calibration 8, compliance 1, current cap 0
// - error queue is first-in first-out with next, all, clear and count
// - queued error code range sets standard bit 5, 4, 3 or 2
// - event bits latch, ignore repeats, clear only by read, clear status or power-up
// - each set's summary is the OR of event AND enable
`timescale 1ns/1ns
module isr_status_core #(
	parameter int ERR_DEPTH = isr_pkg::ERR_DEPTH
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic cmd_valid,
	input wire isr_pkg::isr_cmd_e cmd_code,
	input wire logic [15:0] cmd_data,
	output logic cmd_ready,
	output logic reply_valid,
	output logic [15:0] reply_data,
	input wire logic reply_waiting_flag,
	input wire logic err_push,
	input wire logic [15:0] err_code,
	input wire logic reply_lost,
	input wire logic ops_pending,
	input wire logic interlock_open_flag,
	input wire logic trigger_idle,
	input wire logic event_wait_flag,
	input wire logic link_lost,
	input wire logic cal_fault,
	input wire logic voltage_compliance_reached,
	input wire logic current_cap_reached,
	output logic [7:0] summary_status_byte,
	output logic service_request
);
	localparam int CW = $clog2(ERR_DEPTH + 1);
	localparam int PW = (ERR_DEPTH > 1) ? $clog2(ERR_DEPTH) : 1;

	function automatic logic in_range(input logic [15:0] code, input logic signed [15:0] lo,
		input logic signed [15:0] hi);
		logic signed [15:0] c;
		c = signed'(code);
		in_range = (c >= lo) && (c <= hi);
	endfunction : in_range

	// state
	logic [7:0] request_enable_mask, next_request_enable_mask;
	logic [7:0] standard_event_flags, next_standard_event_flags;
	logic [7:0] standard_enable, next_standard_enable;
	logic [15:0] operation_event_flags, next_operation_event_flags;
	logic [15:0] operation_enable, next_operation_enable;
	logic [15:0] operation_cond_prev, next_operation_cond_prev;
	logic [15:0] questionable_event_flags, next_questionable_event_flags;
	logic [15:0] questionable_enable, next_questionable_enable;
	logic [15:0] questionable_cond_prev, next_questionable_cond_prev;
	logic done_armed, next_done_armed;
	logic [15:0] err_mem [ERR_DEPTH];
	logic [PW-1:0] err_rd, next_err_rd;
	logic [PW-1:0] err_wr, next_err_wr;
	logic [CW-1:0] err_count, next_err_count;
	isr_pkg::isr_state_e state, next_state;
	logic next_cmd_ready;
	logic next_reply_valid;
	logic [15:0] next_reply_data;
	logic [7:0] next_summary_status_byte;
	logic next_service_request;

	// live conditions and summaries
	logic [15:0] operation_cond;
	logic [15:0] questionable_cond;
	logic operation_summary_flag;
	logic standard_summary_flag;
	logic questionable_summary_flag;
	logic err_available;
	logic master_summary_flag;
	logic [7:0] status_now;
	logic take;
	logic pop;
	logic push_ok;
	logic clear_q;
	logic [7:0] err_std_set;

	always_comb begin
		operation_cond = 16'h0000;
		operation_cond[isr_pkg::OP_INTERLOCK] = interlock_open_flag;
		operation_cond[isr_pkg::OP_IDLE] = trigger_idle;
		operation_cond[isr_pkg::OP_WAIT_EVENT_WAIT_FLAG] = event_wait_flag;
		operation_cond[isr_pkg::OP_WAIT_ARM] = 1'b0;
		questionable_cond = 16'h0000;
		questionable_cond[isr_pkg::QU_LINK_LOST] = link_lost;
		questionable_cond[isr_pkg::QU_CAL_FAULT] = cal_fault;
		questionable_cond[isr_pkg::QU_VOLT_COMPL] = voltage_compliance_reached;
		questionable_cond[isr_pkg::QU_CURRENT_CAP] = current_cap_reached;
	end

	// summaries are pure gates on the latched events, never held on their own
	always_comb begin
		operation_summary_flag = |(operation_event_flags & operation_enable);
		standard_summary_flag = |(standard_event_flags & standard_enable);
		questionable_summary_flag = |(questionable_event_flags & questionable_enable);
		err_available = (err_count != '0);
		status_now = 8'h00;
		status_now[isr_pkg::SB_OSB] = operation_summary_flag;
		status_now[isr_pkg::SB_ESB] = standard_summary_flag;
		status_now[isr_pkg::SB_MAV] = reply_waiting_flag;
		status_now[isr_pkg::SB_QSB] = questionable_summary_flag;
		status_now[isr_pkg::SB_EAV] = err_available;
		// the master bit itself is excluded from its own source
		master_summary_flag = |(status_now & request_enable_mask);
		status_now[isr_pkg::SB_MSS] = master_summary_flag;
	end

	// error code classification onto standard bits
	always_comb begin
		err_std_set = 8'h00;
		if (err_push) begin
			err_std_set[isr_pkg::SE_CME] =
				in_range(err_code, isr_pkg::CME_LO, isr_pkg::CME_HI);
			err_std_set[isr_pkg::SE_EXE] =
				in_range(err_code, isr_pkg::EXE_LO, isr_pkg::EXE_HI);
			err_std_set[isr_pkg::SE_DSE] = in_range(err_code, isr_pkg::DSE_LO, isr_pkg::DSE_HI);
			err_std_set[isr_pkg::SE_QYE] = in_range(err_code, isr_pkg::QYE_LO, isr_pkg::QYE_HI);
		end
	end

	// command handling and event registers
	always_comb begin
		take = cmd_valid && cmd_ready;
		pop = 1'b0;
		next_state = state;
		next_cmd_ready = 1'b1;
		next_reply_valid = 1'b0;
		next_reply_data = reply_data;
		next_request_enable_mask = request_enable_mask;
		next_standard_enable = standard_enable;
		next_operation_enable = operation_enable;
		next_questionable_enable = questionable_enable;
		next_standard_event_flags = standard_event_flags;
		next_operation_event_flags = operation_event_flags;
		next_questionable_event_flags = questionable_event_flags;
		next_operation_cond_prev = operation_cond;
		next_questionable_cond_prev = questionable_cond;
		next_done_armed = done_armed;
		if (take) begin
			next_reply_valid = 1'b1;
			unique case (cmd_code)
				isr_pkg::CMD_READ_STATUS: next_reply_data = {8'h00, status_now};
				isr_pkg::CMD_WRITE_SRE: begin
					next_request_enable_mask = cmd_data[7:0];
					next_reply_valid = 1'b0;
				end
				isr_pkg::CMD_READ_SRE: next_reply_data = {8'h00, request_enable_mask};
				isr_pkg::CMD_READ_ESR: begin
					next_reply_data = {8'h00, standard_event_flags};
					next_standard_event_flags = 8'h00;
				end
				isr_pkg::CMD_WRITE_ESE: begin
					next_standard_enable = cmd_data[7:0];
					next_reply_valid = 1'b0;
				end
				isr_pkg::CMD_READ_ESE: next_reply_data = {8'h00, standard_enable};
				isr_pkg::CMD_READ_OPER_EVENT: begin
					next_reply_data = operation_event_flags;
					next_operation_event_flags = 16'h0000;
				end
				isr_pkg::CMD_READ_OPER_COND: next_reply_data = operation_cond;
				isr_pkg::CMD_WRITE_OPER_ENABLE: begin
					next_operation_enable = cmd_data;
					next_reply_valid = 1'b0;
				end
				isr_pkg::CMD_READ_OPER_ENABLE: next_reply_data = operation_enable;
				isr_pkg::CMD_READ_QUES_EVENT: begin
					next_reply_data = questionable_event_flags;
					next_questionable_event_flags = 16'h0000;
				end
				isr_pkg::CMD_READ_QUES_COND: next_reply_data = questionable_cond;
				isr_pkg::CMD_WRITE_QUES_ENABLE: begin
					next_questionable_enable = cmd_data;
					next_reply_valid = 1'b0;
				end
				isr_pkg::CMD_READ_QUES_ENABLE: next_reply_data = questionable_enable;
				isr_pkg::CMD_CLEAR_STATUS: begin
					// clear status empties the error queue as well
					next_standard_event_flags = 8'h00;
					next_operation_event_flags = 16'h0000;
					next_questionable_event_flags = 16'h0000;
					next_reply_valid = 1'b0;
				end
				isr_pkg::CMD_OP_COMPLETE: begin
					next_done_armed = 1'b1;
					next_reply_valid = 1'b0;
				end
				isr_pkg::CMD_ERR_NEXT: begin
					next_reply_data = err_available ? err_mem[err_rd] : isr_pkg::NO_ERROR;
					pop = err_available;
				end
				isr_pkg::CMD_ERR_ALL: begin
					next_reply_data = err_available ? err_mem[err_rd] : isr_pkg::NO_ERROR;
					pop = err_available;
					if (err_count > CW'(1)) begin
						next_state = isr_pkg::ST_DRAIN;
						next_cmd_ready = 1'b0;
					end
				end
				isr_pkg::CMD_ERR_CLEAR: begin
					next_reply_valid = 1'b0;
				end
				isr_pkg::CMD_ERR_COUNT: next_reply_data = 16'(err_count);
			endcase
		end else if (state == isr_pkg::ST_DRAIN) begin
			// one entry per cycle until the queue is empty; commands wait meanwhile
			next_reply_valid = 1'b1;
			next_reply_data = err_mem[err_rd];
			pop = 1'b1;
			next_cmd_ready = (err_count == CW'(1));
			if (err_count == CW'(1)) begin
				next_state = isr_pkg::ST_IDLE;
			end else begin
				next_cmd_ready = 1'b0;
			end
		end
		// sets are applied after clears so an event in the clearing cycle survives
		next_operation_event_flags = next_operation_event_flags |
			(operation_cond & ~operation_cond_prev);
		next_questionable_event_flags = next_questionable_event_flags |
			(questionable_cond & ~questionable_cond_prev);
		next_standard_event_flags = next_standard_event_flags | err_std_set;
		next_standard_event_flags[isr_pkg::SE_QYE] =
			next_standard_event_flags[isr_pkg::SE_QYE] | reply_lost;
		if (done_armed && !ops_pending) begin
			next_standard_event_flags[isr_pkg::SE_OPC] = 1'b1;
			next_done_armed = 1'b0;
		end
		next_operation_event_flags[isr_pkg::OP_WAIT_ARM] = 1'b0;
		next_summary_status_byte = status_now;
		next_service_request = master_summary_flag;
	end

	// error queue pointers; a full queue drops the newcomer, keeping the oldest
	always_comb begin
		clear_q = take && (cmd_code == isr_pkg::CMD_ERR_CLEAR ||
			cmd_code == isr_pkg::CMD_CLEAR_STATUS);
		// a clear frees room, so a push in the clearing cycle is never dropped
		push_ok = err_push && (clear_q || err_count != CW'(ERR_DEPTH));
		next_err_rd = err_rd;
		next_err_wr = err_wr;
		if (pop) begin
			next_err_rd = (err_rd == PW'(ERR_DEPTH - 1)) ? '0 : err_rd + PW'(1);
		end
		if (push_ok) begin
			next_err_wr = (err_wr == PW'(ERR_DEPTH - 1)) ? '0 : err_wr + PW'(1);
		end
		if (clear_q) begin
			// a push in the clearing cycle still lands in the emptied queue
			next_err_rd = err_wr;
			next_err_wr = push_ok ? next_err_wr : err_wr;
			next_err_count = push_ok ? CW'(1) : '0;
		end else begin
			next_err_count = err_count + CW'(push_ok) - CW'(pop);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (push_ok) begin
			err_mem[err_wr] <= err_code;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state <= isr_pkg::ST_IDLE;
			cmd_ready <= 1'b0;
			reply_valid <= 1'b0;
			reply_data <= 16'h0000;
			request_enable_mask <= isr_pkg::MASK8_RESET;
			standard_enable <= isr_pkg::MASK8_RESET;
			operation_enable <= isr_pkg::MASK16_RESET;
			questionable_enable <= isr_pkg::MASK16_RESET;
			standard_event_flags <= isr_pkg::SE_RESET;
			operation_event_flags <= 16'h0000;
			questionable_event_flags <= 16'h0000;
			operation_cond_prev <= 16'h0000;
			questionable_cond_prev <= 16'h0000;
			done_armed <= 1'b0;
			err_rd <= '0;
			err_wr <= '0;
			err_count <= '0;
			summary_status_byte <= 8'h00;
			service_request <= 1'b0;
		end else begin
			state <= next_state;
			cmd_ready <= next_cmd_ready;
			reply_valid <= next_reply_valid;
			reply_data <= next_reply_data;
			request_enable_mask <= next_request_enable_mask;
			standard_enable <= next_standard_enable;
			operation_enable <= next_operation_enable;
			questionable_enable <= next_questionable_enable;
			standard_event_flags <= next_standard_event_flags;
			operation_event_flags <= next_operation_event_flags;
			questionable_event_flags <= next_questionable_event_flags;
			operation_cond_prev <= next_operation_cond_prev;
			questionable_cond_prev <= next_questionable_cond_prev;
			done_armed <= next_done_armed;
			err_rd <= next_err_rd;
			err_wr <= next_err_wr;
			err_count <= next_err_count;
			summary_status_byte <= next_summary_status_byte;
			service_request <= next_service_request;
		end
	end
endmodule : isr_status_core

// ==== tb/isr_status_core_checker.sv ====
// Purpose: concurrent checks on the status reporting core ports
// Assumes: status byte and replies are registered one cycle after their cause
// Notes: masks are internal, so checks lean on replies and live inputs
`timescale 1ns/1ns
module isr_status_core_checker #(
	parameter int ERR_DEPTH = 16
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic cmd_valid,
	input wire isr_pkg::isr_cmd_e cmd_code,
	input wire logic cmd_ready,
	input wire logic reply_valid,
	input wire logic [15:0] reply_data,
	input wire logic reply_waiting_flag,
	input wire logic err_push,
	input wire logic interlock_open_flag,
	input wire logic trigger_idle,
	input wire logic event_wait_flag,
	input wire logic link_lost,
	input wire logic cal_fault,
	input wire logic voltage_compliance_reached,
	input wire logic current_cap_reached,
	input wire logic [7:0] summary_status_byte,
	input wire logic service_request
);
	wire logic take = cmd_valid && cmd_ready;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);
	a_srq_follows_master: assert property (service_request == summary_status_byte[6])
		else $error("service request differs from master bit");
	a_reply_wait_bit: assert property (summary_status_byte[4] == $past(reply_waiting_flag))
		else $error("reply waiting bit does not follow its input");
	a_reserved_arm_bit: assert property (take && cmd_code inside {isr_pkg::CMD_READ_OPER_EVENT,
		isr_pkg::CMD_READ_OPER_COND} |=> !reply_data[6])
		else $error("reserved operation bit seen set");
	a_byte_reply_upper: assert property (take && cmd_code inside {isr_pkg::CMD_READ_STATUS,
		isr_pkg::CMD_READ_SRE, isr_pkg::CMD_READ_ESR, isr_pkg::CMD_READ_ESE}
		|=> reply_valid && reply_data[15:8] == 8'h00)
		else $error("byte reply missing or upper byte not zero");
	a_write_no_reply: assert property (take && cmd_code inside {isr_pkg::CMD_WRITE_SRE,
		isr_pkg::CMD_WRITE_ESE, isr_pkg::CMD_CLEAR_STATUS} |=> !reply_valid)
		else $error("reply given to a write");
	a_oper_cond_live: assert property (take && cmd_code == isr_pkg::CMD_READ_OPER_COND
		|=> reply_valid && reply_data[12] == $past(interlock_open_flag)
		&& reply_data[10] == $past(trigger_idle) && reply_data[5] == $past(event_wait_flag))
		else $error("operation condition reply not live");
	a_ques_cond_live: assert property (take && cmd_code == isr_pkg::CMD_READ_QUES_COND
		|=> reply_data[9:8] == $past({link_lost, cal_fault})
		&& reply_data[1:0] == $past({voltage_compliance_reached, current_cap_reached}))
		else $error("questionable condition reply not live");
	a_error_avail_bit: assert property ((err_push && !cmd_valid) ##1 !cmd_valid
		|=> summary_status_byte[2])
		else $error("error available bit missing after a push");
	c_esr_read: cover property (take && cmd_code == isr_pkg::CMD_READ_ESR);
	c_srq_rise: cover property ($rose(service_request));
	c_drain: cover property (!cmd_ready ##1 !cmd_ready);
endmodule : isr_status_core_checker

bind isr_status_core isr_status_core_checker #(.ERR_DEPTH(ERR_DEPTH)) u_chk (
	.ref_clk(ref_clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
	.cmd_ready(cmd_ready), .reply_valid(reply_valid), .reply_data(reply_data),
	.reply_waiting_flag(reply_waiting_flag), .err_push(err_push),
	.interlock_open_flag(interlock_open_flag), .trigger_idle(trigger_idle),
	.event_wait_flag(event_wait_flag), .link_lost(link_lost), .cal_fault(cal_fault),
	.voltage_compliance_reached(voltage_compliance_reached),
	.current_cap_reached(current_cap_reached),
	.summary_status_byte(summary_status_byte), .service_request(service_request)
);

// ==== tb/isr_host_model.sv ====
// Purpose: remote host issuing decoded status commands
// Assumes: requests change just after a rising edge and hold until taken or for at most 64 cycles
// Notes: released data is inverted so a late sample cannot match by luck
`timescale 1ns/1ns
module isr_host_model (
	input wire logic ref_clk,
	input wire logic cmd_ready,
	input wire logic reply_valid,
	input wire logic [15:0] reply_data,
	output isr_pkg::isr_cmd_e cmd_code,
	output logic cmd_valid,
	output logic [15:0] cmd_data
);
	initial begin
		cmd_valid = 1'b0;
		cmd_code = isr_pkg::CMD_READ_STATUS;
		cmd_data = 16'h0000;
	end
	// request held until cmd_ready is sampled high, or for at most 64 cycles
	task automatic xfer(input isr_pkg::isr_cmd_e code, input logic [15:0] data,
		output logic [15:0] rd);
		int n;
		n = 0;
		cmd_code <= code;
		cmd_data <= data;
		cmd_valid <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (cmd_ready !== 1'b1 && n < 64);
		cmd_valid <= 1'b0;
		cmd_data <= ~data;
		@(posedge ref_clk);
		rd = (reply_valid === 1'b1) ? reply_data : 16'hdead;
	endtask : xfer
endmodule : isr_host_model

// ==== tb/tb_instrument_status_reporting.sv ====
// Purpose: self-checking bench for the status reporting core
// Assumes: error queue shrunk to four entries to reach the full case quickly
// Notes: tests run in order and rely on the state left by the previous one
`timescale 1ns/1ns
module tb_instrument_status_reporting;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic reply_waiting_flag = 1'b0, err_push = 1'b0, reply_lost = 1'b0, ops_pending = 1'b0;
	logic interlock_open_flag = 1'b0, trigger_idle = 1'b0, event_wait_flag = 1'b0;
	logic link_lost = 1'b0, cal_fault = 1'b0;
	logic voltage_compliance_reached = 1'b0, current_cap_reached = 1'b0;
	logic [15:0] err_code = 16'h0000;
	logic cmd_valid, cmd_ready, reply_valid, service_request;
	logic [15:0] cmd_data, reply_data;
	logic [7:0] summary_status_byte;
	isr_pkg::isr_cmd_e cmd_code;
	int bad_count = 0;
	int n_tests = 0;
	always #25 ref_clk = ~ref_clk;
	isr_host_model h (.ref_clk(ref_clk), .cmd_ready(cmd_ready), .reply_valid(reply_valid),
		.reply_data(reply_data), .cmd_code(cmd_code), .cmd_valid(cmd_valid),
		.cmd_data(cmd_data));
	isr_status_core #(.ERR_DEPTH(4)) u_dut (.ref_clk(ref_clk), .resetn(resetn),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_data(cmd_data),
		.cmd_ready(cmd_ready), .reply_valid(reply_valid), .reply_data(reply_data),
		.reply_waiting_flag(reply_waiting_flag), .err_push(err_push), .err_code(err_code),
		.reply_lost(reply_lost), .ops_pending(ops_pending),
		.interlock_open_flag(interlock_open_flag), .trigger_idle(trigger_idle),
		.event_wait_flag(event_wait_flag), .link_lost(link_lost), .cal_fault(cal_fault),
		.voltage_compliance_reached(voltage_compliance_reached),
		.current_cap_reached(current_cap_reached),
		.summary_status_byte(summary_status_byte), .service_request(service_request));
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : cyc
	task automatic q(input isr_pkg::isr_cmd_e c, input logic [15:0] d, input logic [15:0] e);
		logic [15:0] rd;
		h.xfer(c, d, rd);
		chk(c.name(), e, rd);
	endtask : q
	task automatic w(input isr_pkg::isr_cmd_e c, input logic [15:0] d);
		logic [15:0] rd;
		h.xfer(c, d, rd);
	endtask : w
	task automatic sb(input logic [7:0] e);
		chk("status byte", {8'h00, e}, {8'h00, summary_status_byte});
	endtask : sb
	task automatic push(input logic [15:0] c);
		err_code <= c;
		err_push <= 1'b1;
		@(posedge ref_clk);
		err_push <= 1'b0;
		@(posedge ref_clk);
	endtask : push
	task automatic t_reset();
		q(isr_pkg::CMD_READ_ESR, 16'h0000, 16'h0080);
		q(isr_pkg::CMD_READ_ESR, 16'h0000, 16'h0000);
		$display("test reset done");
	endtask : t_reset
	task automatic t_reply();
		reply_waiting_flag <= 1'b1;
		cyc(2);
		sb(8'h10);
		reply_waiting_flag <= 1'b0;
		cyc(2);
		sb(8'h00);
		$display("test reply flag done");
	endtask : t_reply
	task automatic t_errors();
		logic [15:0] c[8] = '{16'hff9c, 16'hff48, 16'hff38, 16'hfeda, 16'hfed4, 16'hfe93,
			16'hfe70, 16'hfe48};
		// only the first four fit; the rest are dropped but still flag their class
		foreach (c[i]) push(c[i]);
		q(isr_pkg::CMD_READ_ESR, 16'h0000, 16'h003c);
		q(isr_pkg::CMD_ERR_COUNT, 16'h0000, 16'h0004);
		q(isr_pkg::CMD_ERR_NEXT, 16'h0000, 16'hff9c);
		q(isr_pkg::CMD_ERR_ALL, 16'h0000, 16'hff48);
		for (int i = 2; i < 4; i++) begin
			@(posedge ref_clk);
			chk("drain", c[i], reply_data);
			chk("drain ready", 16'(i == 3), {15'h0000, cmd_ready});
		end
		q(isr_pkg::CMD_ERR_COUNT, 16'h0000, 16'h0000);
		cyc(1);
		sb(8'h00);
		push(c[0]);
		w(isr_pkg::CMD_ERR_CLEAR, 16'h0000);
		q(isr_pkg::CMD_ERR_COUNT, 16'h0000, 16'h0000);
		$display("test error queue done");
	endtask : t_errors
	task automatic t_summary();
		w(isr_pkg::CMD_WRITE_ESE, 16'h0020);
		push(16'hff92);
		cyc(2);
		sb(8'h24);
		w(isr_pkg::CMD_WRITE_SRE, 16'h0020);
		cyc(2);
		sb(8'h64);
		chk("service request", 16'h0001, {15'h0000, service_request});
		q(isr_pkg::CMD_READ_STATUS, 16'h0000, 16'h0064);
		sb(8'h64);
		q(isr_pkg::CMD_READ_ESR, 16'h0000, 16'h0020);
		cyc(2);
		sb(8'h04);
		q(isr_pkg::CMD_ERR_NEXT, 16'h0000, 16'hff92);
		w(isr_pkg::CMD_WRITE_OPER_ENABLE, 16'h1000);
		interlock_open_flag <= 1'b1;
		trigger_idle <= 1'b1;
		event_wait_flag <= 1'b1;
		cyc(3);
		sb(8'h80);
		q(isr_pkg::CMD_READ_OPER_COND, 16'h0000, 16'h1420);
		q(isr_pkg::CMD_READ_OPER_EVENT, 16'h0000, 16'h1420);
		q(isr_pkg::CMD_READ_OPER_EVENT, 16'h0000, 16'h0000);
		cyc(2);
		sb(8'h00);
		w(isr_pkg::CMD_WRITE_QUES_ENABLE, 16'h0200);
		{link_lost, cal_fault, voltage_compliance_reached, current_cap_reached} <= 4'hf;
		cyc(3);
		sb(8'h08);
		q(isr_pkg::CMD_READ_QUES_COND, 16'h0000, 16'h0303);
		w(isr_pkg::CMD_CLEAR_STATUS, 16'h0000);
		cyc(2);
		sb(8'h00);
		q(isr_pkg::CMD_READ_QUES_EVENT, 16'h0000, 16'h0000);
		$display("test summaries done");
	endtask : t_summary
	task automatic t_opc();
		ops_pending <= 1'b1;
		w(isr_pkg::CMD_OP_COMPLETE, 16'h0000);
		cyc(3);
		q(isr_pkg::CMD_READ_ESR, 16'h0000, 16'h0000);
		ops_pending <= 1'b0;
		reply_lost <= 1'b1;
		@(posedge ref_clk);
		reply_lost <= 1'b0;
		cyc(2);
		q(isr_pkg::CMD_READ_ESR, 16'h0000, 16'h0005);
		$display("test completion done");
	endtask : t_opc
	task automatic t_masks();
		w(isr_pkg::CMD_WRITE_SRE, 16'h003c);
		q(isr_pkg::CMD_READ_SRE, 16'h0000, 16'h003c);
		w(isr_pkg::CMD_WRITE_ESE, 16'h00bd);
		q(isr_pkg::CMD_READ_ESE, 16'h0000, 16'h00bd);
		w(isr_pkg::CMD_WRITE_OPER_ENABLE, 16'h1420);
		q(isr_pkg::CMD_READ_OPER_ENABLE, 16'h0000, 16'h1420);
		w(isr_pkg::CMD_WRITE_QUES_ENABLE, 16'h0303);
		q(isr_pkg::CMD_READ_QUES_ENABLE, 16'h0000, 16'h0303);
		$display("test masks done");
	endtask : t_masks
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : summarize
	initial begin
		cyc(20);
		resetn <= 1'b1;
		cyc(2);
		t_reset();
		t_reply();
		t_errors();
		t_summary();
		t_opc();
		t_masks();
		summarize();
	end
	// the whole sequence needs well under a thousand cycles
	initial begin
		#(50 * 20000);
		bad_count++;
		summarize();
	end
endmodule : tb_instrument_status_reporting
